// ===== design/fcl_defines.svh
// constants for the logic-cell fabric model
// assumes inclusion by the package and the fabric module only
`ifndef FCL_DEFINES_SVH
`define FCL_DEFINES_SVH
`define FCL_SEL_B 2'h0
`define FCL_SEL_C 2'h1
`define FCL_SEL_QX 2'h2
`define FCL_SEL_QY 2'h3
`define FCL_LUT_LO 1'b0
`define FCL_LUT_HI 1'b1
`define FCL_KEEP_RST 1'b1
`define FCL_ROWS 8
`define FCL_COLS 8
`endif

// ===== design/fcl_fabric.sv
// logic-cell array with direct neighbour links, row long-line buses and clock selection
// assumes static configuration ports held steady while cfg_loaded is high
// Notes on behaviour
// - dual option: two four-input functions, shared A, two picks, D or E
// - five-input option: one function of A, D, E and two picks, both outputs equal
// - muxed option: E selects between two functions sharing A and D
// - first output reaches B of right neighbour and C of left neighbour directly
// - second output reaches D of cell above and A of cell below directly
// - every switch stays open until configuration is loaded
// - two three-state buffers per cell drive the row line while control is low
// - same signal on data and control gives open-drain wired-AND
// - enabled pull-ups make an undriven line read high
// - weak keeper holds last level when nothing drives the line
// - global net or routed input selectable as each cell's flop clock
// - alternate buffer network reaches columns with vertical link, selectable as clock
// - isolation buffer enabled only when a driving connection is configured
// - global net optionally drives the die-edge clock line
`include "fcl_defines.svh"
module fcl_fabric #(
  parameter int ROWS = `FCL_ROWS,
  parameter int COLS = `FCL_COLS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cfg_loaded,
  input wire fcl_pkg::fcl_cell_cfg_s [ROWS*COLS-1:0] cell_cfg,
  input wire logic [ROWS-1:0][1:0] row_pullup,
  input wire logic [COLS-1:0] col_alt_link,
  input wire logic edge_clk_en,
  input wire fcl_pkg::fcl_pins_s [ROWS*COLS-1:0] cell_pins,
  input wire logic gclk_pin,
  input wire logic aclk_pin,
  output logic [ROWS*COLS-1:0] cell_x,
  output logic [ROWS*COLS-1:0] cell_y,
  output logic [ROWS-1:0] longline,
  output logic [ROWS-1:0] line_clash,
  output logic edge_clk
);
  localparam int N = ROWS * COLS;

  typedef struct packed {
    fcl_pkg::fcl_pins_s [N-1:0] s1;
    fcl_pkg::fcl_pins_s [N-1:0] s2;
    logic [N-1:0] kprev;
    logic g1;
    logic g2;
    logic gprev;
    logic a1;
    logic a2;
    logic aprev;
    logic [N-1:0] qx;
    logic [N-1:0] qy;
    logic [N-1:0] x;
    logic [N-1:0] y;
    logic [ROWS-1:0] keep;
    logic [ROWS-1:0] clash;
    logic edge_clk;
  } fcl_state_s;

  fcl_state_s q;
  fcl_state_s d;
  logic ok;
  logic gtick;
  logic atick;
  logic [N-1:0] f_w;
  logic [N-1:0] g_w;
  logic [N-1:0] tick_w;
  logic [2*N-1:0] lo_w;
  logic [2*N-1:0] hi_w;
  logic [ROWS-1:0] row_lo;
  logic [ROWS-1:0] row_hi;
  logic [ROWS-1:0] line_w;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  function automatic logic pick(input logic [3:0] pool, input logic [1:0] sel);
    logic r;
    r = 1'b0;
    case (sel)
      `FCL_SEL_B: r = pool[0];
      `FCL_SEL_C: r = pool[1];
      `FCL_SEL_QX: r = pool[2];
      `FCL_SEL_QY: r = pool[3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick

  // without a loaded configuration no switch conducts
  assign ok = cfg_loaded;
  // edges are taken on synchronised pins; flops therefore see the clock two samples late
  assign gtick = q.g2 & ~q.gprev;
  assign atick = q.a2 & ~q.aprev;

  for (genvar r = 0; r < ROWS; r++)
  begin : g_row
    for (genvar c = 0; c < COLS; c++)
    begin : g_col
      localparam int I = r * COLS + c;
      fcl_pkg::fcl_cell_cfg_s cf;
      fcl_pkg::fcl_pins_s p;
      logic a_in;
      logic b_in;
      logic c_in;
      logic d_in;
      logic e_in;
      logic [3:0] pool;
      logic fr;
      logic gr;
      logic tk;
      assign cf = cell_cfg[I];
      assign p = q.s2[I];
      assign e_in = p.e;
      // direct links use registered neighbour outputs, which keeps the array free of loops
      if (r > 0)
      begin : g_a
        assign a_in = (ok && cf.a_direct) ? q.y[I-COLS] : p.a;
      end
      else
      begin : g_a0
        assign a_in = p.a;
      end
      if (r < ROWS - 1)
      begin : g_d
        assign d_in = (ok && cf.d_direct) ? q.y[I+COLS] : p.d;
      end
      else
      begin : g_d0
        assign d_in = p.d;
      end
      if (c > 0)
      begin : g_b
        assign b_in = (ok && cf.b_direct) ? q.x[I-1] : p.b;
      end
      else
      begin : g_b0
        assign b_in = p.b;
      end
      if (c < COLS - 1)
      begin : g_c
        assign c_in = (ok && cf.c_direct) ? q.x[I+1] : p.c;
      end
      else
      begin : g_c0
        assign c_in = p.c;
      end
      assign pool = {q.qy[I], q.qx[I], c_in, b_in};

      always_comb
      begin
        fr = 1'b0;
        gr = 1'b0;
        case (cf.mode)
          fcl_pkg::FCL_DUAL:
          begin
            fr = cf.lut[{`FCL_LUT_LO, a_in, pick(pool, cf.f_sel.s2), pick(pool, cf.f_sel.s3),
                         (cf.f_sel.s4 ? e_in : d_in)}];
            gr = cf.lut[{`FCL_LUT_HI, a_in, pick(pool, cf.g_sel.s2), pick(pool, cf.g_sel.s3),
                         (cf.g_sel.s4 ? e_in : d_in)}];
          end
          fcl_pkg::FCL_FIVE:
          begin
            fr = cf.lut[{e_in, d_in, a_in, pick(pool, cf.f_sel.s2), pick(pool, cf.f_sel.s3)}];
            gr = fr;
          end
          fcl_pkg::FCL_MUX:
          begin
            if (e_in)
              fr = cf.lut[{`FCL_LUT_HI, a_in, d_in, pick(pool, cf.g_sel.s2), pick(pool, cf.g_sel.s3)}];
            else
              fr = cf.lut[{`FCL_LUT_LO, a_in, d_in, pick(pool, cf.f_sel.s2), pick(pool, cf.f_sel.s3)}];
            gr = fr;
          end
          default:
          begin
            fr = 1'b0;
            gr = 1'b0;
          end
        endcase
      end

      always_comb
      begin
        tk = 1'b0;
        case (cf.clk_src)
          fcl_pkg::FCL_CK_GLOBAL: tk = gtick;
          fcl_pkg::FCL_CK_ALT: tk = col_alt_link[c] & atick;
          fcl_pkg::FCL_CK_ROUTED: tk = q.s2[I].k & ~q.kprev[I];
          default: tk = 1'b0;
        endcase
      end

      assign f_w[I] = ok & fr;
      assign g_w[I] = ok & gr;
      assign tick_w[I] = ok & tk;

      for (genvar k = 0; k < 2; k++)
      begin : g_tbuf
        logic dat;
        logic ctl;
        logic on;
        assign dat = cf.tbuf[k].from_y ? q.y[I] : q.x[I];
        assign ctl = cf.tbuf[k].wired ? dat : p.t[k];
        // isolation buffer only opens for a configured driving connection
        assign on = ok & cf.tbuf[k].used & ~ctl;
        assign lo_w[2*I+k] = on & ~dat;
        assign hi_w[2*I+k] = on & dat;

        tbuf_iso_a: assert property (!(ok && cf.tbuf[k].used) |-> !lo_w[2*I+k] && !hi_w[2*I+k])
          else $error("unconfigured buffer drives the line");
        wired_and_a: assert property (ok && cf.tbuf[k].used && cf.tbuf[k].wired && dat |-> !hi_w[2*I+k])
          else $error("wired-and buffer drives high");
      end

      five_same_a: assert property (ok && cf.mode == fcl_pkg::FCL_FIVE |=> cell_x[I] == cell_y[I])
        else $error("five-input outputs differ");
      mux_same_a: assert property (ok && cf.mode == fcl_pkg::FCL_MUX |=> cell_x[I] == cell_y[I])
        else $error("muxed outputs differ");
      flop_hold_a: assert property (!tick_w[I] |=> q.qx[I] == $past(q.qx[I]) && q.qy[I] == $past(q.qy[I]))
        else $error("cell flop changed without a clock edge");
      alt_gate_a: assert property (cf.clk_src == fcl_pkg::FCL_CK_ALT && !col_alt_link[c] |-> !tick_w[I])
        else $error("alternate clock reached an unlinked column");
    end

    assign row_lo[r] = |lo_w[2*r*COLS +: 2*COLS];
    assign row_hi[r] = |hi_w[2*r*COLS +: 2*COLS];

    always_comb
    begin
      if (row_lo[r])
        line_w[r] = 1'b0;
      else if (row_hi[r])
        line_w[r] = 1'b1;
      else if (ok && (|row_pullup[r]))
        line_w[r] = 1'b1;
      else
        line_w[r] = q.keep[r];
    end

    line_low_a: assert property (row_lo[r] |=> !longline[r])
      else $error("line not low with a low driver");
    pullup_high_a: assert property (!row_lo[r] && !row_hi[r] && ok && (|row_pullup[r]) |=> longline[r])
      else $error("pulled-up idle line not high");
    keeper_hold_a: assert property (!row_lo[r] && !row_hi[r] && !(ok && (|row_pullup[r])) |=> $stable(longline[r]))
      else $error("keeper lost the line level");
  end

  always_comb
  begin
    d = q;
    d.s1 = cell_pins;
    d.s2 = q.s1;
    d.g1 = gclk_pin;
    d.g2 = q.g1;
    d.gprev = q.g2;
    d.a1 = aclk_pin;
    d.a2 = q.a1;
    d.aprev = q.a2;
    for (int i = 0; i < N; i++)
    begin
      d.kprev[i] = q.s2[i].k;
      d.x[i] = f_w[i];
      d.y[i] = g_w[i];
      if (tick_w[i])
      begin
        d.qx[i] = f_w[i];
        d.qy[i] = g_w[i];
      end
    end
    d.keep = line_w;
    // contention is only reported; avoiding it is the user's job
    d.clash = row_lo & row_hi;
    d.edge_clk = ok & edge_clk_en & q.g2;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.keep <= {ROWS{`FCL_KEEP_RST}};
    end
    else
    begin
      q <= d;
    end
  end

  assign cell_x = q.x;
  assign cell_y = q.y;
  assign longline = q.keep;
  assign line_clash = q.clash;
  assign edge_clk = q.edge_clk;

  unconfig_quiet_a: assert property (!cfg_loaded |=> cell_x == '0 && cell_y == '0 && !edge_clk)
    else $error("unconfigured fabric drives outputs");
  edge_clk_a: assert property (!edge_clk_en |=> !edge_clk)
    else $error("edge clock driven while disabled");
endmodule : fcl_fabric

// ===== design/fcl_pkg.sv
// types for the logic-cell fabric model
// assumes fcl_defines.svh is on the include path
`include "fcl_defines.svh"
package fcl_pkg;
  typedef enum logic [1:0] {
    FCL_DUAL = 2'h0,
    FCL_FIVE = 2'h1,
    FCL_MUX = 2'h3,
    FCL_MODE_RSV = 2'h2
  } fcl_mode_e;
  typedef enum logic [1:0] {
    FCL_CK_NONE = 2'h0,
    FCL_CK_GLOBAL = 2'h1,
    FCL_CK_ALT = 2'h3,
    FCL_CK_ROUTED = 2'h2
  } fcl_clk_e;
  typedef struct packed {
    logic [1:0] s2;
    logic [1:0] s3;
    logic s4;
  } fcl_fsel_s;
  typedef struct packed {
    logic used;
    logic from_y;
    logic wired;
  } fcl_tbuf_s;
  typedef struct packed {
    logic [31:0] lut;
    fcl_mode_e mode;
    fcl_fsel_s f_sel;
    fcl_fsel_s g_sel;
    logic a_direct;
    logic b_direct;
    logic c_direct;
    logic d_direct;
    fcl_tbuf_s [1:0] tbuf;
    fcl_clk_e clk_src;
  } fcl_cell_cfg_s;
  typedef struct packed {
    logic k;
    logic [1:0] t;
    logic e;
    logic d;
    logic c;
    logic b;
    logic a;
  } fcl_pins_s;
endpackage : fcl_pkg

// ===== verification/tb_top.sv
// bench for the logic-cell fabric: cell functions, direct links, row long line, clock selection
// assumes fcl_pkg and fcl_fabric compiled first; a 2x2 array reaches every neighbour case
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] L = 32'h6a3c95e1;
  logic clk;
  logic sys_rst;
  logic cfg_loaded;
  fcl_pkg::fcl_cell_cfg_s [3:0] cfg;
  fcl_pkg::fcl_cell_cfg_s [3:0] nc;
  logic [1:0][1:0] row_pullup;
  logic [1:0] col_alt_link;
  logic edge_clk_en;
  fcl_pkg::fcl_pins_s [3:0] pins;
  logic gclk_pin;
  logic aclk_pin;
  logic [3:0] cell_x;
  logic [3:0] cell_y;
  logic [1:0] longline;
  logic [1:0] line_clash;
  logic edge_clk;
  int err_total;
  int compares;
  int cycles;

  fcl_fabric #(.ROWS(2), .COLS(2)) i_dut (.clk(clk), .sys_rst(sys_rst), .cfg_loaded(cfg_loaded),
    .cell_cfg(cfg), .row_pullup(row_pullup), .col_alt_link(col_alt_link), .edge_clk_en(edge_clk_en),
    .cell_pins(pins), .gclk_pin(gclk_pin), .aclk_pin(aclk_pin), .cell_x(cell_x), .cell_y(cell_y),
    .longline(longline), .line_clash(line_clash), .edge_clk(edge_clk));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic rst;
    sys_rst = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
  endtask : rst

  // configuration only changes while unloaded, as the fabric expects
  task automatic load;
    cfg_loaded = 1'b0;
    cyc(1);
    cfg = nc;
    cyc(1);
    cfg_loaded = 1'b1;
  endtask : load

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // a driving cell is set up but the fabric stays unloaded
  task automatic test_idle;
    nc[0].lut = 32'hff00ff00;
    nc[0].tbuf[0] = 3'h5;
    cfg = nc;
    gclk_pin = 1'b1;
    edge_clk_en = 1'b1;
    cyc(6);
    chk(cell_x, 4'h0);
    chk(4'(longline), 4'h3);
    chk(4'(edge_clk), 4'h0);
    gclk_pin = 1'b0;
    $display("test idle done");
  endtask : test_idle

  task automatic test_func;
    logic [1:0] m;
    logic [4:0] p;
    logic f;
    logic g;
    nc = '0;
    nc[0].lut = L;
    nc[0].f_sel = 5'h02;
    nc[0].g_sel = 5'h02;
    for (int k = 0; k < 4; k++)
    begin
      m = 2'(k ^ (k >> 1));
      nc[0].mode = fcl_pkg::fcl_mode_e'(m);
      load();
      for (int i = 0; i < 32; i++)
      begin
        p = 5'(i);
        pins[0] = {3'h0, p};
        cyc(3);
        f = (m == 2'h0) ? L[{1'b0, p[0], p[1], p[2], p[3]}] : (m == 2'h1) ? L[{p[4], p[3], p[0], p[1], p[2]}]
          : (m == 2'h3) ? L[{p[4], p[0], p[3], p[1], p[2]}] : 1'b0;
        g = (m == 2'h0) ? L[{1'b1, p[0], p[1], p[2], p[3]}] : f;
        chk(4'(cell_x[0]), 4'(f));
        chk(4'(cell_y[0]), 4'(g));
      end
    end
    $display("test func done");
  endtask : test_func

  // cell 0 is an open-drain driver, cell 1 a bus driver held off by its control
  task automatic test_line;
    nc = '0;
    nc[0].lut = 32'hff00ff00;
    nc[0].tbuf[0] = 3'h5;
    nc[1].lut = 32'hff00ff00;
    nc[1].tbuf[1] = 3'h4;
    pins = '0;
    pins[1].t = 2'h3;
    row_pullup = '0;
    load();
    cyc(4);
    chk(4'(longline[0]), 4'h0);
    pins[0].a = 1'b1;
    cyc(4);
    chk(4'(longline[0]), 4'h0);
    row_pullup[0] = 2'h2;
    cyc(2);
    chk(4'(longline[0]), 4'h1);
    pins[1].t = 2'h1;
    cyc(4);
    chk(4'(longline[0]), 4'h0);
    chk(4'(longline[1]), 4'h1);
    // cell 0 stays released while cell 1 turns its bus level high, so no opposing drivers meet
    row_pullup[0] = 2'h0;
    pins[1].a = 1'b1;
    cyc(4);
    chk(4'(longline[0]), 4'h1);
    chk(4'(line_clash), 4'h0);
    $display("test line done");
  endtask : test_line

  // routed pins on the receivers are set high so a missing link shows up
  task automatic test_direct;
    nc = '0;
    nc[0].lut = 32'hff00ff00;
    nc[1].lut = 32'hf0f0f0f0;
    nc[1].b_direct = 1'b1;
    nc[2].lut = 32'hff00ff00;
    nc[2].a_direct = 1'b1;
    pins = '0;
    pins[1].b = 1'b1;
    pins[2].a = 1'b1;
    load();
    cyc(4);
    chk(cell_x, 4'h0);
    pins[0].a = 1'b1;
    cyc(4);
    chk(cell_x, 4'h7);
    // cell 3 feeds C of its left neighbour and D of the cell above
    nc = '0;
    nc[1].lut = 32'haaaaaaaa;
    nc[1].d_direct = 1'b1;
    nc[2].lut = 32'hcccccccc;
    nc[2].f_sel = 5'h0a;
    nc[2].c_direct = 1'b1;
    nc[3].lut = 32'hff00ff00;
    pins = '0;
    pins[1].d = 1'b1;
    pins[2].c = 1'b1;
    load();
    cyc(4);
    chk(cell_x, 4'h0);
    pins[3].a = 1'b1;
    cyc(4);
    chk(cell_x, 4'he);
    $display("test direct done");
  endtask : test_direct

  // cell 0 is a toggle flop: its first function is the inverse of the first flop state
  task automatic test_clock;
    nc = '0;
    nc[0].lut = 32'h00000f0f;
    nc[0].f_sel = 5'h12;
    nc[0].clk_src = fcl_pkg::FCL_CK_GLOBAL;
    pins = '0;
    col_alt_link = '0;
    load();
    rst();
    cyc(2);
    chk(4'(cell_x[0]), 4'h1);
    gclk_pin = 1'b1;
    cyc(4);
    chk(4'(cell_x[0]), 4'h0);
    chk(4'(edge_clk), 4'h1);
    gclk_pin = 1'b0;
    cyc(4);
    chk(4'(edge_clk), 4'h0);
    nc[0].clk_src = fcl_pkg::FCL_CK_ALT;
    for (int k = 0; k < 2; k++)
    begin
      col_alt_link = 2'(k);
      load();
      aclk_pin = 1'b1;
      cyc(4);
      aclk_pin = 1'b0;
      cyc(2);
      chk(4'(cell_x[0]), 4'(k));
    end
    // routed clock: the flop toggles on a rising k pin and holds on its fall
    nc[0].clk_src = fcl_pkg::FCL_CK_ROUTED;
    load();
    pins[0].k = 1'b1;
    cyc(4);
    chk(4'(cell_x[0]), 4'h0);
    pins[0].k = 1'b0;
    cyc(4);
    chk(4'(cell_x[0]), 4'h0);
    $display("test clock done");
  endtask : test_clock

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      end_sim();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    cfg_loaded = 1'b0;
    cfg = '0;
    nc = '0;
    row_pullup = '0;
    col_alt_link = '0;
    edge_clk_en = 1'b0;
    pins = '0;
    gclk_pin = 1'b0;
    aclk_pin = 1'b0;
    rst();
    test_idle();
    test_func();
    test_line();
    test_direct();
    test_clock();
    end_sim();
  end
endmodule : tb_top
